// *** design/fwh_word_handler.sv ***
// Fieldbus word handler: command word decode, state word
// assembly and the four-word parameter channel.
// Assumes master and drive logic run on clk.
`timescale 1ns/100ps
`default_nettype none
`include "fwh_consts.svh"
// Functional notes
// - Command bit0 run, bit1 reverse, bit2 external fault, bit3 fault reset.
// - Command bits 6-13 virtual inputs, bit14 controller mode, bit15 torque.
// - State bits 0-3: running, reverse, ready, faulted.
// - State bits 4-12: warning through no output, in order.
// - State bit13 ref not link, bit14 run source, bit15 over-torque.
// - Channel is head, subentry, fault value, parameter value words.
// - Head bits 0-11 carry the parameter number.
// - Response code 0 none, 1 processed, 7 not processable.
// - Fault number in low byte of third word, upper byte zero.
// - Fault 0 when the parameter does not exist.
// - Fault 1 when the parameter cannot be read or written now.
// - Fault 2 when a modify value is out of range.
// - Fault 101 on other drive link faults such as timeout.
// - Parameter data travels in the fourth word.
// - Good read echoes head and subentry, zero third, value fourth.
// - Cyclic command word goes to register 0x2501.
// - Cyclic state word comes from register 0x2520.
module fwh_word_handler
   import fwh_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = `FWH_TIMEOUT_CYCLES
)
(
   input wire logic clk, // 125 MHz
   input wire logic arst_n, // Async reset
   input wire logic cmd_valid, // Cyclic command word strobe
   input wire logic [15:0] cmd_word, // Cyclic command word
   output logic run_cmd, // Run
   output logic reverse_cmd, // Reverse
   output logic ext_fault_cmd, // External fault
   output logic fault_reset_cmd, // Fault reset
   output logic [7:0] virtual_inputs, // virtual_input_1..8
   output logic controller_mode, // Controller mode
   output logic link_torque_en, // Torque command by link
   output logic [15:0] drive_command_word, // Command register
   input wire logic st_running, // Running
   input wire logic st_reverse, // Reverse
   input wire logic st_ready, // Ready to operate
   input wire logic st_faulted, // Faulted
   input wire logic st_warning, // Warning
   input wire logic st_zero_speed, // Zero speed
   input wire logic st_model_flag, // Model flag
   input wire logic st_freq_reached, // Frequency reached
   input wire logic st_any_freq, // Any frequency reached
   input wire logic st_freq_det1, // Frequency detection 1
   input wire logic st_freq_det2, // Frequency detection 2
   input wire logic st_low_voltage, // Low voltage
   input wire logic st_no_output, // No output
   input wire logic st_ref_not_link, // Reference not from link
   input wire logic run_source_not_link, // Run source not link
   input wire logic st_over_torque, // Over-torque
   output logic [15:0] drive_state_word, // State register
   input wire logic req_valid, // Request strobe
   output logic req_ready, // Idle, request taken
   input wire logic [15:0] req_head, // param_request_head
   input wire logic [15:0] req_subentry_word, // Subentry
   input wire logic [15:0] req_fault_value_word, // Zero
   input wire logic [15:0] req_param_value_word, // Data
   output logic rsp_valid, // Response pulse
   output logic [15:0] rsp_head, // Response head
   output logic [15:0] rsp_subentry_word, // Echo
   output logic [15:0] rsp_fault_value_word, // Fault
   output logic [15:0] rsp_param_value_word, // Data
   output logic drv_req, // Drive access request
   output logic drv_we, // Drive write
   output logic [15:0] drv_addr, // Drive address
   output logic [15:0] drv_wdata, // Drive write data
   input wire logic drv_ack, // Drive answer pulse
   input wire logic [15:0] drv_rdata, // Drive read data
   input wire logic [1:0] drv_err // Drive error code
);
   localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);
   fwh_state_t state, next_state;
   logic [15:0] next_cmd, next_state_word;
   logic next_rsp_valid, next_drv_req, next_drv_we;
   fwh_word_t next_rsp_head, next_rsp_sub, next_rsp_fault, next_rsp_value;
   fwh_word_t next_drv_addr, next_drv_wdata, acc_addr;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [3:0] req_code;
   logic [7:0] drv_fault;
   assign req_ready = (state == ST_IDLE);
   assign req_code = req_head[`FWH_CODE_MSB:`FWH_CODE_LSB];
   // A zero number selects the subentry word as address
   assign acc_addr = (req_head[11:0] != 12'h000) ? {4'h0, req_head[11:0]}
      : req_subentry_word;

   // Decoded commands are slices of the command register
   assign run_cmd = drive_command_word[`FWH_CW_RUN];
   assign reverse_cmd = drive_command_word[`FWH_CW_REV];
   assign ext_fault_cmd = drive_command_word[`FWH_CW_EXT_FAULT];
   assign fault_reset_cmd = drive_command_word[`FWH_CW_FAULT_RST];
   assign controller_mode = drive_command_word[`FWH_CW_CTRL_MODE];
   assign link_torque_en = drive_command_word[`FWH_CW_TORQUE];
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_vin
         assign virtual_inputs[gi] = drive_command_word[`FWH_CW_VIN_LSB + gi];
      end
   endgenerate
   always_comb
      next_state_word = {st_over_torque, run_source_not_link, st_ref_not_link,
         st_no_output, st_low_voltage, st_freq_det2, st_freq_det1,
         st_any_freq, st_freq_reached, st_model_flag, st_zero_speed,
         st_warning,
         st_faulted, st_ready, st_reverse, st_running};
   always_comb
      case (drv_err)
         `FWH_DRV_NO_PARAM: drv_fault = `FWH_FAULT_NO_PARAM;
         `FWH_DRV_STATE: drv_fault = `FWH_FAULT_STATE;
         default: drv_fault = `FWH_FAULT_RANGE;
      endcase

   always_comb
   begin
      next_state = state;
      next_cmd = drive_command_word;
      next_rsp_valid = 1'b0;
      next_rsp_head = rsp_head;
      next_rsp_sub = rsp_subentry_word;
      next_rsp_fault = rsp_fault_value_word;
      next_rsp_value = rsp_param_value_word;
      next_drv_req = drv_req;
      next_drv_we = drv_we;
      next_drv_addr = drv_addr;
      next_drv_wdata = drv_wdata;
      next_cnt = cnt;
      case (state)
         ST_IDLE:
         begin
            if (req_valid)
            begin
               next_rsp_valid = 1'b1;
               next_rsp_sub = req_subentry_word;
               next_rsp_fault = 16'h0000;
               next_rsp_value = 16'h0000;
               if (req_code == `FWH_REQ_NONE)
                  next_rsp_head = {`FWH_RSP_NONE, req_head[11:0]};
               else if (req_code != `FWH_REQ_READ && req_code != `FWH_REQ_MODIFY)
               begin
                  next_rsp_head = {`FWH_RSP_FAIL, req_head[11:0]};
                  next_rsp_fault = {8'h00, `FWH_FAULT_OTHER};
               end
               else if (acc_addr == `FWH_CMD_REG_ADDR)
               begin
                  if (req_code == `FWH_REQ_READ)
                  begin
                     // Command register is write only
                     next_rsp_head = {`FWH_RSP_FAIL, req_head[11:0]};
                     next_rsp_fault = {8'h00, `FWH_FAULT_STATE};
                  end
                  else
                  begin
                     next_cmd = req_param_value_word & `FWH_CW_KEEP_MASK;
                     next_rsp_head = {`FWH_RSP_DONE, req_head[11:0]};
                     next_rsp_value = req_param_value_word;
                  end
               end
               else if (acc_addr == `FWH_STAT_REG_ADDR)
               begin
                  if (req_code == `FWH_REQ_MODIFY)
                  begin
                     next_rsp_head = {`FWH_RSP_FAIL, req_head[11:0]};
                     next_rsp_fault = {8'h00, `FWH_FAULT_STATE};
                  end
                  else
                  begin
                     next_rsp_head = {`FWH_RSP_DONE, req_head[11:0]};
                     next_rsp_value = drive_state_word;
                  end
               end
               else
               begin
                  // Held until the drive answers or the wait expires
                  next_rsp_valid = 1'b0;
                  next_rsp_head = req_head;
                  next_drv_req = 1'b1;
                  next_drv_we = (req_code == `FWH_REQ_MODIFY);
                  next_drv_addr = acc_addr;
                  next_drv_wdata = req_param_value_word;
                  next_cnt = '0;
                  next_state = ST_ACCESS;
               end
            end
         end
         ST_ACCESS:
         begin
            if (drv_ack)
            begin
               next_drv_req = 1'b0;
               next_rsp_valid = 1'b1;
               next_state = ST_IDLE;
               if (drv_err == `FWH_DRV_OK)
               begin
                  next_rsp_head = {`FWH_RSP_DONE, rsp_head[11:0]};
                  next_rsp_value = drv_we ? drv_wdata : drv_rdata;
               end
               else
               begin
                  next_rsp_head = {`FWH_RSP_FAIL, rsp_head[11:0]};
                  next_rsp_fault = {8'h00, drv_fault};
               end
            end
            else if (cnt == CNT_LAST)
            begin
               next_drv_req = 1'b0;
               next_rsp_valid = 1'b1;
               next_state = ST_IDLE;
               next_rsp_head = {`FWH_RSP_FAIL, rsp_head[11:0]};
               next_rsp_fault = {8'h00, `FWH_FAULT_OTHER};
            end
            else
               next_cnt = CNT_W'(cnt + 1'b1);
         end
         default: next_state = ST_IDLE;
      endcase
      // Cyclic word wins over a same-cycle parameter write
      if (cmd_valid)
         next_cmd = cmd_word & `FWH_CW_KEEP_MASK;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= ST_IDLE;
         drive_command_word <= `FWH_CMD_RESET;
         drive_state_word <= 16'h0000;
         rsp_valid <= 1'b0;
         rsp_head <= 16'h0000;
         rsp_subentry_word <= 16'h0000;
         rsp_fault_value_word <= 16'h0000;
         rsp_param_value_word <= 16'h0000;
         drv_req <= 1'b0;
         drv_we <= 1'b0;
         drv_addr <= 16'h0000;
         drv_wdata <= 16'h0000;
         cnt <= '0;
      end
      else
      begin
         state <= next_state;
         drive_command_word <= next_cmd;
         drive_state_word <= next_state_word;
         rsp_valid <= next_rsp_valid;
         rsp_head <= next_rsp_head;
         rsp_subentry_word <= next_rsp_sub;
         rsp_fault_value_word <= next_rsp_fault;
         rsp_param_value_word <= next_rsp_value;
         drv_req <= next_drv_req;
         drv_we <= next_drv_we;
         drv_addr <= next_drv_addr;
         drv_wdata <= next_drv_wdata;
         cnt <= next_cnt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_run_decode: assert property (
      cmd_valid |=> run_cmd == $past(cmd_word[0]) && reverse_cmd == $past(cmd_word[1]))
      else $error("run or direction not decoded from command word");
   a_vin_map: assert property (
      cmd_valid |=> virtual_inputs == $past(cmd_word[13:6])
         && link_torque_en == $past(cmd_word[15]))
      else $error("virtual inputs or torque bit wrong");
   a_rsvd_ignored: assert property (
      ##1 drive_command_word[5:4] == 2'b00)
      else $error("reserved command bits stored");
   a_state_low: assert property (
      arst_n |=> drive_state_word[3:0] == {$past(st_faulted), $past(st_ready),
         $past(st_reverse), $past(st_running)})
      else $error("state word low bits wrong");
   a_state_mid: assert property (
      arst_n |=> drive_state_word[4] == $past(st_warning)
         && drive_state_word[12] == $past(st_no_output))
      else $error("state word middle bits wrong");
   a_state_high: assert property (
      arst_n |=> drive_state_word[14] == $past(run_source_not_link)
         && drive_state_word[15] == $past(st_over_torque))
      else $error("state word high bits wrong");
   a_none_code: assert property (
      req_valid && req_ready && req_code == `FWH_REQ_NONE
      |=> rsp_valid && rsp_head[15:12] == `FWH_RSP_NONE && !drv_req)
      else $error("no-request code not answered with zero");
   a_bad_code: assert property (
      req_valid && req_ready && req_code > `FWH_REQ_MODIFY
      |=> rsp_valid && rsp_head[15:12] == `FWH_RSP_FAIL && rsp_fault_value_word == 16'h0065)
      else $error("unknown code not refused");
   a_fault_byte: assert property (
      rsp_valid |-> rsp_fault_value_word[15:8] == 8'h00)
      else $error("fault word upper byte not zero");
   a_range_map: assert property (
      state == ST_ACCESS && drv_ack && drv_err == `FWH_DRV_RANGE
      |=> rsp_valid && rsp_fault_value_word[7:0] == 8'h02)
      else $error("range error not reported as 2");
   a_no_param_map: assert property (
      state == ST_ACCESS && drv_ack && drv_err == `FWH_DRV_NO_PARAM
      |=> rsp_valid && rsp_head[15:12] == `FWH_RSP_FAIL && rsp_fault_value_word[7:0] == 8'h00)
      else $error("missing parameter not reported as 0");
   a_read_echo: assert property (
      state == ST_ACCESS && drv_ack && drv_err == `FWH_DRV_OK && !drv_we
      |=> rsp_valid && rsp_fault_value_word == 16'h0000
         && rsp_param_value_word == $past(drv_rdata))
      else $error("read response not formed");
   a_timeout: assert property (
      state == ST_ACCESS && !drv_ack && cnt == CNT_LAST
      |=> rsp_valid && !drv_req && rsp_fault_value_word[7:0] == 8'h65)
      else $error("drive timeout not reported as 101");
   a_stat_local: assert property (
      req_valid && req_ready && req_code == `FWH_REQ_READ
         && acc_addr == `FWH_STAT_REG_ADDR
      |=> rsp_valid && !drv_req && rsp_param_value_word == $past(drive_state_word))
      else $error("state register read not served locally");

   c_drive_read: cover property (
      state == ST_ACCESS && drv_ack && !drv_we && drv_err == `FWH_DRV_OK);
   c_drive_fail: cover property (state == ST_ACCESS && drv_ack && drv_err != `FWH_DRV_OK);
   c_timeout: cover property (state == ST_ACCESS && cnt == CNT_LAST && !drv_ack);
   c_cmd_param: cover property (
      req_valid && req_ready && req_code == `FWH_REQ_MODIFY && acc_addr == `FWH_CMD_REG_ADDR);
endmodule : fwh_word_handler
`default_nettype wire

// *** design/fwh_consts.svh ***
// Constants for the fieldbus word handler.
// Included by the handler module.
`ifndef FWH_CONSTS_SVH
`define FWH_CONSTS_SVH
`define FWH_CMD_REG_ADDR 16'h2501
`define FWH_STAT_REG_ADDR 16'h2520
`define FWH_CW_RUN 0
`define FWH_CW_REV 1
`define FWH_CW_EXT_FAULT 2
`define FWH_CW_FAULT_RST 3
`define FWH_CW_VIN_LSB 6
`define FWH_CW_CTRL_MODE 14
`define FWH_CW_TORQUE 15
`define FWH_CW_KEEP_MASK 16'hffcf
`define FWH_CMD_RESET 16'h0000
`define FWH_CODE_MSB 15
`define FWH_CODE_LSB 12
`define FWH_REQ_NONE 4'h0
`define FWH_REQ_READ 4'h1
`define FWH_REQ_MODIFY 4'h2
`define FWH_RSP_NONE 4'h0
`define FWH_RSP_DONE 4'h1
`define FWH_RSP_FAIL 4'h7
`define FWH_FAULT_NO_PARAM 8'h00
`define FWH_FAULT_STATE 8'h01
`define FWH_FAULT_RANGE 8'h02
`define FWH_FAULT_OTHER 8'h65
`define FWH_DRV_OK 2'h0
`define FWH_DRV_NO_PARAM 2'h1
`define FWH_DRV_STATE 2'h2
`define FWH_DRV_RANGE 2'h3
`define FWH_CLK_PERIOD_NS 8
`define FWH_TIMEOUT_NS 10000
`define FWH_TIMEOUT_CYCLES (`FWH_TIMEOUT_NS / `FWH_CLK_PERIOD_NS)
`endif

// *** design/fwh_pkg.sv ***
// Types for the fieldbus word handler.
// Assumes fwh_consts.svh is on the include path.
package fwh_pkg;
   typedef enum logic [0:0] {ST_IDLE, ST_ACCESS} fwh_state_t;
   typedef logic [15:0] fwh_word_t;
endpackage : fwh_pkg

// *** verif/fwh_drive_model.sv ***
// Behavioural drive behind the handler's drive access port.
// Assumes one access at a time, held until this model answers.
`timescale 1ns/100ps
`default_nettype none
module fwh_drive_model
(
   input wire logic clk, // Clock
   input wire logic arst_n, // Async reset
   input wire logic drv_req, // Access request
   input wire logic drv_we, // Write
   input wire logic [15:0] drv_addr, // Address
   input wire logic [15:0] drv_wdata, // Write data
   output logic drv_ack, // Answer pulse
   output logic [15:0] drv_rdata, // Read data
   output logic [1:0] drv_err, // Error code
   input wire logic [3:0] dly, // Answer delay in cycles
   input wire logic mute // Never answer
);
   logic [15:0] mem [0:63];
   logic [3:0] wait_cnt;
   logic [1:0] code;

   always_comb
   begin
      code = 2'h0;
      if (drv_addr == 16'h0ffe)
         code = 2'h2;
      else if (drv_addr > 16'h003f)
         code = 2'h1;
      else if (drv_we && drv_wdata[15])
         code = 2'h3;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         drv_ack <= 1'b0;
         drv_rdata <= 16'h0000;
         drv_err <= 2'h0;
         wait_cnt <= 4'h0;
         mem[5] <= 16'h0004;
      end
      else
      begin
         drv_ack <= 1'b0;
         // Idle lines toggle so stale data never passes for an answer
         drv_rdata <= ~drv_rdata;
         drv_err <= ~drv_err;
         if (drv_req && !drv_ack && !mute)
         begin
            if (wait_cnt != dly)
               wait_cnt <= wait_cnt + 4'h1;
            else
            begin
               wait_cnt <= 4'h0;
               drv_ack <= 1'b1;
               drv_err <= code;
               drv_rdata <= drv_we ? drv_wdata : mem[drv_addr[5:0]];
               if (drv_we && code == 2'h0)
                  mem[drv_addr[5:0]] <= drv_wdata;
            end
         end
      end
   end
endmodule : fwh_drive_model
`default_nettype wire

// *** verif/fwh_word_handler_tb.sv ***
// Testbench for the fieldbus word handler.
// Assumes the drive model answers on the drive access port.
`timescale 1ns/100ps
`default_nettype none
module fwh_word_handler_tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic req_valid = 1'b0;
   logic mute = 1'b0;
   logic [3:0] dly = 4'h0;
   logic [15:0] cmd_word = 16'h0000;
   logic [15:0] flags = 16'h0000;
   logic [15:0] req_head = 16'h0000;
   logic [15:0] req_sub = 16'h0000;
   logic [15:0] req_val = 16'h0000;
   logic run_cmd, reverse_cmd, ext_fault_cmd, fault_reset_cmd, controller_mode, link_torque_en;
   logic req_ready, rsp_valid, drv_req, drv_we, drv_ack;
   logic [7:0] virtual_inputs;
   logic [15:0] drive_command_word, drive_state_word, rsp_head, rsp_sub, rsp_fault, rsp_val;
   logic [15:0] drv_addr, drv_wdata, drv_rdata;
   logic [1:0] drv_err;
   int n_mismatch = 0;
   int n_tests = 0;
   int i;

   fwh_word_handler #(.TIMEOUT_CYCLES(8)) uut
   (
      .clk, .arst_n, .cmd_valid, .cmd_word, .run_cmd, .reverse_cmd, .ext_fault_cmd,
      .fault_reset_cmd, .virtual_inputs, .controller_mode, .link_torque_en,
      .drive_command_word, .st_running(flags[0]), .st_reverse(flags[1]),
      .st_ready(flags[2]), .st_faulted(flags[3]), .st_warning(flags[4]),
      .st_zero_speed(flags[5]), .st_model_flag(flags[6]), .st_freq_reached(flags[7]),
      .st_any_freq(flags[8]), .st_freq_det1(flags[9]), .st_freq_det2(flags[10]),
      .st_low_voltage(flags[11]), .st_no_output(flags[12]), .st_ref_not_link(flags[13]),
      .run_source_not_link(flags[14]), .st_over_torque(flags[15]), .drive_state_word,
      .req_valid, .req_ready, .req_head, .req_subentry_word(req_sub),
      .req_fault_value_word(16'h0000), .req_param_value_word(req_val), .rsp_valid,
      .rsp_head, .rsp_subentry_word(rsp_sub), .rsp_fault_value_word(rsp_fault),
      .rsp_param_value_word(rsp_val), .drv_req, .drv_we, .drv_addr, .drv_wdata,
      .drv_ack, .drv_rdata, .drv_err
   );

   fwh_drive_model drive
   (
      .clk, .arst_n, .drv_req, .drv_we, .drv_addr, .drv_wdata, .drv_ack, .drv_rdata,
      .drv_err, .dly, .mute
   );

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic xfer(input logic [15:0] h, s, v, eh, ef, ev);
      int k;
      @(posedge clk);
      req_valid <= 1'b1;
      req_head <= h;
      req_sub <= s;
      req_val <= v;
      k = 0;
      // Keep offering the same request until it is taken
      do
      begin
         @(posedge clk);
         k++;
      end
      while (req_ready !== 1'b1 && k < 40);
      req_valid <= 1'b0;
      do
      begin
         @(negedge clk);
         k++;
      end
      while (rsp_valid !== 1'b1 && k < 80);
      if (k >= 80)
      begin
         n_mismatch++;
         $display("ERROR %0t: no response to request", $time);
         close_out();
      end
      else
      begin
         chk(rsp_head, eh);
         chk(rsp_sub, s);
         chk(rsp_fault, ef);
         chk(rsp_val, ev);
      end
   endtask : xfer

   task automatic cmd(input logic [15:0] w);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_word <= w;
      @(posedge clk);
      cmd_valid <= 1'b0;
      @(negedge clk);
      chk(drive_command_word, w & 16'hffcf);
      chk({link_torque_en, controller_mode, virtual_inputs, 2'b00, fault_reset_cmd,
         ext_fault_cmd, reverse_cmd, run_cmd}, w & 16'hffcf);
   endtask : cmd

   initial
   begin
      forever #4 clk = ~clk;
   end

   initial
   begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      for (i = 0; i < 16; i++)
         cmd(16'h0001 << i);
      cmd(16'hffff);
      for (i = 0; i < 16; i++)
      begin
         @(posedge clk);
         flags <= 16'h0001 << i;
         @(posedge clk);
         @(negedge clk);
         chk(drive_state_word, 16'h0001 << i);
      end
      @(posedge clk);
      flags <= 16'ha5a5;
      xfer(16'h0005, 16'h0000, 16'h0000, 16'h0005, 16'h0000, 16'h0000);
      xfer(16'h1000, 16'h0005, 16'h0000, 16'h1000, 16'h0000, 16'h0004);
      dly <= 4'h5;
      xfer(16'h1005, 16'h0000, 16'h0000, 16'h1005, 16'h0000, 16'h0004);
      xfer(16'h2010, 16'h0000, 16'h0123, 16'h1010, 16'h0000, 16'h0123);
      dly <= 4'h0;
      xfer(16'h1010, 16'h0000, 16'h0000, 16'h1010, 16'h0000, 16'h0123);
      xfer(16'h1fff, 16'h0000, 16'h0000, 16'h7fff, 16'h0000, 16'h0000);
      xfer(16'h1ffe, 16'h0000, 16'h0000, 16'h7ffe, 16'h0001, 16'h0000);
      xfer(16'h2011, 16'h0000, 16'h8000, 16'h7011, 16'h0002, 16'h0000);
      mute <= 1'b1;
      xfer(16'h1020, 16'h0000, 16'h0000, 16'h7020, 16'h0065, 16'h0000);
      mute <= 1'b0;
      for (i = 3; i < 16; i++)
         xfer({i[3:0], 12'h005}, 16'h0000, 16'h0000, 16'h7005, 16'h0065, 16'h0000);
      xfer(16'h1000, 16'h2501, 16'h0000, 16'h7000, 16'h0001, 16'h0000);
      xfer(16'h2000, 16'h2501, 16'h0031, 16'h1000, 16'h0000, 16'h0031);
      repeat (2) @(negedge clk);
      chk(drive_command_word, 16'h0001);
      xfer(16'h2000, 16'h2520, 16'h0000, 16'h7000, 16'h0001, 16'h0000);
      xfer(16'h1000, 16'h2520, 16'h0000, 16'h1000, 16'h0000, 16'ha5a5);
      // Mid-run reset clears every handler register, then the flags come back
      @(posedge clk);
      arst_n <= 1'b0;
      @(negedge clk);
      chk(drive_command_word, 16'h0000);
      chk(drive_state_word, 16'h0000);
      chk(rsp_head, 16'h0000);
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      xfer(16'h1000, 16'h2520, 16'h0000, 16'h1000, 16'h0000, 16'ha5a5);
      close_out();
   end
endmodule : fwh_word_handler_tb
`default_nettype wire
